// ==== lspi_params.svh ====
// constants of the line-side pin interface: offsets, fields, resets, timing
// assumes a 100 MHz system clock and word-aligned register offsets
// Overview of operation
// - transmit rails change just after the rising edge, or falling edge when inverted.
// - rails only run in bipolar mode, transmit line clock in bipolar or unipolar mode, both with pins enabled.
// - analog transmit outputs only run in bipolar mode with line unit enabled.
// - rails may be inverted; analog transmit outputs never are.
// - receive rails only used in bipolar mode with line unit disabled.
// - receive rails sampled on rising edge, or falling edge when clock inverted.
// - receive line clock is the only timing reference for receive rails.
// - receive rails have selectable polarity inversion.
// - recovered data leaves on the serial output delayed, otherwise unchanged.
// - unipolar transmit data only active in unipolar mode with pins enabled.
// - unipolar data changes after rising edge, or falling edge when inverted.
// - unipolar transmit data may be inverted; far side picks its reference clock.
// - unipolar data and violation inputs only used in unipolar mode.
// - with serial output enabled every unipolar bit appears, none dropped.
// - violation counter adds one each receive clock the violation input is high, until it saturates at all ones.
// - unipolar inputs sampled on rising edge, or falling edge when clock inverted.
// - unipolar data and violation inputs have selectable polarity inversion.
`ifndef LSPI_PARAMS_SVH
`define LSPI_PARAMS_SVH
`define LSPI_ADDR_CTRL     8'h00
`define LSPI_ADDR_STAT     8'h04
`define LSPI_ADDR_BPV      8'h08
`define LSPI_CTRL_W        9
`define LSPI_CTRL_RST      9'h000
`define LSPI_STAT_SEEN     0
`define LSPI_BPV_W         16
`define LSPI_CLK_PERIOD_NS 10
`define LSPI_TX_HALF_NS    80
`define LSPI_TX_HALF_CYC   ((`LSPI_TX_HALF_NS) / (`LSPI_CLK_PERIOD_NS))
`endif

// ==== lspi_pkg.sv ====
// types shared by the line-side pin interface modules
// assumes lspi_params.svh supplies the widths used here
`include "lspi_params.svh"
package lspi_pkg;
  typedef enum logic [1:0] {
    LSPI_MODE_B3ZS = 2'b00,
    LSPI_MODE_AMI  = 2'b01,
    LSPI_MODE_UNI  = 2'b10,
    LSPI_MODE_OFF  = 2'b11
  } lspi_mode_t;

  // control word, bit 0 upward: mode, line unit, pins, inversions, serial out
  typedef struct packed {
    logic       rx_serial_out_en;
    logic       rx_data_inv;
    logic       rx_clk_inv;
    logic       tx_data_inv;
    logic       tx_clk_inv;
    logic       tx_pins_en;
    logic       liu_en;
    lspi_mode_t mode;
  } lspi_cfg_t;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic       clk_d;
    logic       smp;
    logic       pos;
    logic       neg;
    logic       dat;
    logic       lcv;
  } lspi_rx_st_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
    logic       upd;
    logic       pos;
    logic       neg;
    logic       dat;
  } lspi_tx_st_t;

  // both bipolar codings share the rail pins
  function automatic logic lspi_is_bipolar(input lspi_mode_t m);
    return (m == LSPI_MODE_B3ZS) || (m == LSPI_MODE_AMI);
  endfunction
endpackage

// ==== lspi_link_if.sv ====
// internal carrier between the pin core and its transmit and receive halves
// assumes all three modules run on the same system clock
`timescale 1ns/1ns
interface lspi_link_if;
  lspi_pkg::lspi_cfg_t cfg;
  logic rx_smp, rx_clk, rx_pos, rx_neg, rx_dat, rx_lcv;
  logic tx_clk, tx_upd, tx_pos, tx_neg, tx_dat;
  logic tx_pos_bit, tx_neg_bit, tx_uni_bit;
  modport core (output cfg, tx_pos_bit, tx_neg_bit, tx_uni_bit,
                input rx_smp, rx_clk, rx_pos, rx_neg, rx_dat, rx_lcv,
                input tx_clk, tx_upd, tx_pos, tx_neg, tx_dat);
  modport rx (input cfg, output rx_smp, rx_clk, rx_pos, rx_neg, rx_dat, rx_lcv);
  modport tx (input cfg, tx_pos_bit, tx_neg_bit, tx_uni_bit,
              output tx_clk, tx_upd, tx_pos, tx_neg, tx_dat);
endinterface // lspi_link_if

// ==== lspi_rx_sampler.sv ====
// receive pin sampler: synchronises line clock and data, samples on chosen edge
// assumes the line clock is far slower than clock_i (160 ns against 10 ns)
`timescale 1ns/1ns
module lspi_rx_sampler (
  input  wire logic  clock_i,
  input  wire logic  sys_rst_i,
  input  wire logic  rx_line_clock_i,
  input  wire logic  rx_pos_rail_i,
  input  wire logic  rx_neg_rail_i,
  input  wire logic  rx_unipolar_data_i,
  input  wire logic  rx_line_violation_in_i,
  lspi_link_if.rx    lk
);
  lspi_pkg::lspi_rx_st_t st, next_st;
  logic                  hit;

  // data and clock share one synchroniser depth so they stay aligned
  always_comb
  begin
    next_st       = st;
    next_st.s1    = {rx_line_violation_in_i, rx_unipolar_data_i, rx_neg_rail_i,
                     rx_pos_rail_i, rx_line_clock_i};
    next_st.s2    = st.s1;
    next_st.clk_d = st.s2[0];
    hit = lk.cfg.rx_clk_inv ? (~st.s2[0] & st.clk_d) : (st.s2[0] & ~st.clk_d);
    next_st.smp   = hit;
    if (hit)
    begin
      next_st.pos = st.s2[1] ^ lk.cfg.rx_data_inv;
      next_st.neg = st.s2[2] ^ lk.cfg.rx_data_inv;
      next_st.dat = st.s2[3] ^ lk.cfg.rx_data_inv;
      next_st.lcv = st.s2[4] ^ lk.cfg.rx_data_inv;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign lk.rx_smp = st.smp;
  assign lk.rx_clk = st.clk_d;
  assign lk.rx_pos = st.pos;
  assign lk.rx_neg = st.neg;
  assign lk.rx_dat = st.dat;
  assign lk.rx_lcv = st.lcv;
endmodule // lspi_rx_sampler

// ==== lspi_tx_clocker.sv ====
// transmit timing: divides clock_i into the line clock and loads framer bits
// assumes the framer holds its bits steady between two load pulses
`timescale 1ns/1ns
`include "lspi_params.svh"
module lspi_tx_clocker #(
  parameter int TX_HALF_CYC = `LSPI_TX_HALF_CYC
) (
  input  wire logic  clock_i,
  input  wire logic  sys_rst_i,
  lspi_link_if.tx    lk
);
  lspi_pkg::lspi_tx_st_t st, next_st;
  logic                  wrap;

  if (TX_HALF_CYC < 1 || TX_HALF_CYC > 255)
  begin : g_bad_half
    $error("tx half period must be 1 to 255 cycles");
  end

  // load one cycle after the chosen edge, so the rails change just after it
  always_comb
  begin
    next_st     = st;
    wrap        = (st.cnt == 8'(TX_HALF_CYC - 1));
    next_st.cnt = wrap ? 8'h00 : st.cnt + 8'h01;
    next_st.clk = wrap ? ~st.clk : st.clk;
    next_st.upd = wrap && (st.clk == lk.cfg.tx_clk_inv);
    if (st.upd)
    begin
      next_st.pos = lk.tx_pos_bit;
      next_st.neg = lk.tx_neg_bit;
      next_st.dat = lk.tx_uni_bit;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign lk.tx_clk = st.clk;
  assign lk.tx_upd = st.upd;
  assign lk.tx_pos = st.pos;
  assign lk.tx_neg = st.neg;
  assign lk.tx_dat = st.dat;
endmodule // lspi_tx_clocker

// ==== lspi_line_pins.sv ====
// line-side digital pin interface: registers, mode gating, counter, serial out
// assumes a single-cycle register port; rx pins are asynchronous to clock_i
`timescale 1ns/1ns
`include "lspi_params.svh"
module lspi_line_pins #(
  parameter int TX_HALF_CYC = `LSPI_TX_HALF_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        tx_pos_bit_i,
  input  wire logic        tx_neg_bit_i,
  input  wire logic        tx_uni_bit_i,
  output logic             tx_take_o,
  output logic             tx_pos_rail_o,
  output logic             tx_neg_rail_o,
  output logic             tx_line_clock_o,
  output logic             tx_unipolar_data_o,
  output logic             tx_analog_pos_o,
  output logic             tx_analog_neg_o,
  input  wire logic        rx_line_clock_i,
  input  wire logic        rx_pos_rail_i,
  input  wire logic        rx_neg_rail_i,
  input  wire logic        rx_unipolar_data_i,
  input  wire logic        rx_line_violation_in_i,
  output logic             rx_serial_out_o,
  output logic             rx_bit_valid_o,
  output logic             rx_pos_bit_o,
  output logic             rx_neg_bit_o
);
  // whole core state in one word; the sampler and clocker keep their own
  typedef struct packed {
    lspi_pkg::lspi_cfg_t     cfg;
    logic [`LSPI_BPV_W-1:0]  bpv;
    logic                    seen;
    logic [31:0]             rdata;
    logic                    tx_pos;
    logic                    tx_neg;
    logic                    tx_clk;
    logic                    tx_dat;
    logic                    ana_p;
    logic                    ana_n;
    logic                    take;
    logic                    rx_serial_out;
    logic                    rvalid;
    logic                    rx_pos_rail;
    logic                    rx_neg_rail;
  } lspi_core_st_t;

  lspi_core_st_t st, next_st;
  logic          bip;
  logic          unipolar_mode;
  logic          tx_rail_en;
  logic          tx_clk_en;
  logic          tx_uni_en;
  logic          rx_rail_en;
  logic          bpv_inc;
  logic          bpv_clr;
  logic          seen_clr;
  logic          rx_bit;

  lspi_link_if lk ();

  lspi_rx_sampler u_rx (
    .clock_i                (clock_i),
    .sys_rst_i              (sys_rst_i),
    .rx_line_clock_i        (rx_line_clock_i),
    .rx_pos_rail_i          (rx_pos_rail_i),
    .rx_neg_rail_i          (rx_neg_rail_i),
    .rx_unipolar_data_i     (rx_unipolar_data_i),
    .rx_line_violation_in_i (rx_line_violation_in_i),
    .lk                     (lk.rx)
  );

  lspi_tx_clocker #(
    .TX_HALF_CYC (TX_HALF_CYC)
  ) u_tx (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .lk        (lk.tx)
  );

  // framer bits go straight to the loader; it only takes them on its pulse
  assign lk.cfg        = st.cfg;
  assign lk.tx_pos_bit = tx_pos_bit_i;
  assign lk.tx_neg_bit = tx_neg_bit_i;
  assign lk.tx_uni_bit = tx_uni_bit_i;

  // availability of each pin group in the current mode
  always_comb
  begin
    bip        = lspi_pkg::lspi_is_bipolar(st.cfg.mode);
    unipolar_mode        = (st.cfg.mode == lspi_pkg::LSPI_MODE_UNI);
    tx_rail_en = bip && st.cfg.tx_pins_en;
    tx_uni_en  = unipolar_mode && st.cfg.tx_pins_en;
    tx_clk_en  = tx_rail_en || tx_uni_en;
    rx_rail_en = bip && !st.cfg.liu_en;
  end

  // register side effects; a hardware set always beats a software clear
  always_comb
  begin
    bpv_inc  = lk.rx_smp && unipolar_mode && lk.rx_lcv && (st.bpv != '1);
    bpv_clr  = reg_wr_i && (reg_addr_i == `LSPI_ADDR_BPV);
    seen_clr = reg_wr_i && (reg_addr_i == `LSPI_ADDR_STAT)
               && reg_wdata_i[`LSPI_STAT_SEEN];
  end

  // recovered data: any mark on either rail, or the unipolar bit
  always_comb
  begin
    if (unipolar_mode)
      rx_bit = lk.rx_dat;
    else
      rx_bit = lk.rx_pos | lk.rx_neg;
  end

  always_comb
  begin
    next_st = st;

    // control register write
    if (reg_wr_i && (reg_addr_i == `LSPI_ADDR_CTRL))
      next_st.cfg = lspi_pkg::lspi_cfg_t'(reg_wdata_i[`LSPI_CTRL_W-1:0]);

    // read data stands for the one cycle after the strobe only
    next_st.rdata = 32'h0000_0000;
    if (reg_rd_i)
    begin
      if (reg_addr_i == `LSPI_ADDR_CTRL)
        next_st.rdata = {23'h00_0000, st.cfg};
      else if (reg_addr_i == `LSPI_ADDR_STAT)
        next_st.rdata = {27'h000_0000, lk.rx_lcv, lk.rx_dat, lk.rx_neg, lk.rx_pos,
                         st.seen};
      else if (reg_addr_i == `LSPI_ADDR_BPV)
        next_st.rdata = {16'h0000, st.bpv};
      else
        next_st.rdata = 32'h0000_0000;
    end

    // sticky flag: a receive clock edge was found
    next_st.seen = (st.seen && !seen_clr) || lk.rx_smp;

    // violation counter saturates; a clear in the same cycle keeps the new count
    if (bpv_clr)
      next_st.bpv = bpv_inc ? `LSPI_BPV_W'(1) : '0;
    else if (bpv_inc)
      next_st.bpv = st.bpv + `LSPI_BPV_W'(1);

    // transmit pins: digital rails invertible, analog pair never inverted
    next_st.tx_pos = tx_rail_en && (lk.tx_pos ^ st.cfg.tx_data_inv);
    next_st.tx_neg = tx_rail_en && (lk.tx_neg ^ st.cfg.tx_data_inv);
    next_st.tx_clk = tx_clk_en && lk.tx_clk;
    next_st.tx_dat = tx_uni_en && (lk.tx_dat ^ st.cfg.tx_data_inv);
    next_st.ana_p  = bip && st.cfg.liu_en && lk.tx_pos;
    next_st.ana_n  = bip && st.cfg.liu_en && lk.tx_neg;
    next_st.take   = lk.tx_upd && tx_clk_en;

    // receive side: unavailable pins are dropped, nothing reaches the framer
    next_st.rvalid = 1'b0;
    if (!rx_rail_en)
    begin
      next_st.rx_pos_rail = 1'b0;
      next_st.rx_neg_rail = 1'b0;
    end
    if (lk.rx_smp && (rx_rail_en || unipolar_mode))
    begin
      next_st.rvalid = 1'b1;
      next_st.rx_serial_out   = st.cfg.rx_serial_out_en && rx_bit;
      if (rx_rail_en)
      begin
        next_st.rx_pos_rail = lk.rx_pos;
        next_st.rx_neg_rail = lk.rx_neg;
      end
    end
    if (!st.cfg.rx_serial_out_en)
      next_st.rx_serial_out = 1'b0;
  end

  // the reset value of control holds every transmit pin inactive
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st     <= '0;
      st.cfg <= lspi_pkg::lspi_cfg_t'(`LSPI_CTRL_RST);
    end
    else
      st <= next_st;
  end

  assign reg_rdata_o        = st.rdata;
  assign tx_take_o          = st.take;
  assign tx_pos_rail_o      = st.tx_pos;
  assign tx_neg_rail_o      = st.tx_neg;
  assign tx_line_clock_o    = st.tx_clk;
  assign tx_unipolar_data_o = st.tx_dat;
  assign tx_analog_pos_o    = st.ana_p;
  assign tx_analog_neg_o    = st.ana_n;
  assign rx_serial_out_o    = st.rx_serial_out;
  assign rx_bit_valid_o     = st.rvalid;
  assign rx_pos_bit_o       = st.rx_pos_rail;
  assign rx_neg_bit_o       = st.rx_neg_rail;

  // checks on the pin behaviour
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_tx_rail_gate: assert property (
    !$past(tx_rail_en) |-> !tx_pos_rail_o && !tx_neg_rail_o)
    else $error("transmit rails active outside bipolar pin mode");

  a_tx_clk_gate: assert property (
    !$past(tx_clk_en) |-> !tx_line_clock_o)
    else $error("transmit line clock active while pins disabled");

  a_tx_analog_gate: assert property (
    !$past(bip && st.cfg.liu_en) |-> !tx_analog_pos_o && !tx_analog_neg_o)
    else $error("analog transmit pair driven without line unit");

  a_tx_rail_inv: assert property (
    $past(tx_rail_en) && $past(bip && st.cfg.liu_en)
      |-> (tx_pos_rail_o ^ tx_analog_pos_o) == $past(st.cfg.tx_data_inv))
    else $error("rail and analog polarity relation broken");

  // the pulse was decided on last cycle's control, so skip a control change
  a_tx_load_edge: assert property (
    lk.tx_upd && $stable(st.cfg) |-> lk.tx_clk == !st.cfg.tx_clk_inv)
    else $error("transmit bits loaded on wrong clock edge");

  a_tx_uni_gate: assert property (
    !$past(tx_uni_en) |-> !tx_unipolar_data_o)
    else $error("unipolar transmit data active outside unipolar mode");

  a_rx_edge_pick: assert property (
    lk.rx_smp && $stable(st.cfg) |-> lk.rx_clk == !st.cfg.rx_clk_inv)
    else $error("receive sample taken on wrong clock edge");

  a_rx_rail_drop: assert property (
    !rx_rail_en |=> !rx_pos_bit_o && !rx_neg_bit_o)
    else $error("receive rails used while unavailable");

  a_bpv_count: assert property (
    bpv_inc && !bpv_clr |=> st.bpv == $past(st.bpv) + `LSPI_BPV_W'(1))
    else $error("violation counter missed an increment");

  a_bpv_quiet: assert property (
    !unipolar_mode && !bpv_clr |=> $stable(st.bpv))
    else $error("violation counter moved outside unipolar mode");

  a_rx_serial_out_every_bit: assert property (
    lk.rx_smp && unipolar_mode && st.cfg.rx_serial_out_en && $stable(st.cfg)
      |=> rx_bit_valid_o && (rx_serial_out_o == $past(lk.rx_dat)))
    else $error("unipolar bit missing on serial output");

  a_rdata_window: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data present outside its cycle");

  c_uni_violation: cover property (lk.rx_smp && unipolar_mode && lk.rx_lcv);
  c_bip_rx_bit: cover property (rx_bit_valid_o && (rx_pos_bit_o || rx_neg_bit_o));
  c_tx_inv_edge: cover property (lk.tx_upd && st.cfg.tx_clk_inv && tx_rail_en);
  c_bpv_clr_race: cover property (bpv_inc && bpv_clr);
endmodule // lspi_line_pins

// ==== lspi_far_model.sv ====
// far-side line unit model: drives the receive pins, captures the transmit pins
// assumes the bench calls send() and tells it which transmit clock edge is chosen
`timescale 1ns/1ns
module lspi_far_model (
  input  wire logic       tx_clk_inv_i,
  input  wire logic       tx_line_clock_i,
  input  wire logic       tx_pos_rail_i,
  input  wire logic       tx_neg_rail_i,
  input  wire logic       tx_unipolar_data_i,
  output logic            rx_line_clock_o,
  output logic            rx_pos_rail_o,
  output logic            rx_neg_rail_o,
  output logic            rx_unipolar_data_o,
  output logic            rx_line_violation_in_o,
  output logic      [2:0] tx_seen_o
);
  // line clock idles low so an invert change never fakes an edge
  initial
  begin
    rx_line_clock_o = 1'b0;
    {rx_pos_rail_o, rx_neg_rail_o, rx_unipolar_data_o, rx_line_violation_in_o} = 4'h0;
    tx_seen_o = 3'h0;
  end

  // one 160 ns bit per loop; data spans both clock edges, bit 0 first
  task automatic send(input logic [7:0] p, input logic [7:0] ng,
                      input logic [7:0] d, input logic [7:0] v);
    // start off the system clock edge so no pin moves on a sampling edge
    #3;
    for (int i = 0; i < 8; i++)
    begin
      {rx_pos_rail_o, rx_neg_rail_o, rx_unipolar_data_o, rx_line_violation_in_o} =
        {p[i], ng[i], d[i], v[i]};
      #30 rx_line_clock_o = 1'b1;
      #80 rx_line_clock_o = 1'b0;
      #50;
    end
    // released after the frame: show the inverse, clock stands still
    {rx_pos_rail_o, rx_neg_rail_o, rx_unipolar_data_o, rx_line_violation_in_o} =
      ~{rx_pos_rail_o, rx_neg_rail_o, rx_unipolar_data_o, rx_line_violation_in_o};
  endtask

  // capture on the chosen edge, before the device moves its pins
  always @(posedge tx_line_clock_i)
    if (!tx_clk_inv_i)
      tx_seen_o <= {tx_pos_rail_i, tx_neg_rail_i, tx_unipolar_data_i};
  always @(negedge tx_line_clock_i)
    if (tx_clk_inv_i)
      tx_seen_o <= {tx_pos_rail_i, tx_neg_rail_i, tx_unipolar_data_i};
endmodule // lspi_far_model

// ==== lspi_line_pins_test.sv ====
// self-checking bench for the line-side pin interface with its far-side model
// assumes 100 MHz clock_i, synchronous active-high reset, 160 ns line clocks
`timescale 1ns/1ns
module lspi_line_pins_test;
  localparam int HALF = 8;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        tx_pos_bit_i = 1'b0;
  logic        tx_neg_bit_i = 1'b0;
  logic        tx_uni_bit_i = 1'b0;
  logic        tx_clk_inv = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        tx_take_o, tx_pos_rail_o, tx_neg_rail_o, tx_line_clock_o;
  logic        tx_unipolar_data_o, tx_analog_pos_o, tx_analog_neg_o;
  logic        rx_line_clock_i, rx_pos_rail_i, rx_neg_rail_i;
  logic        rx_unipolar_data_i, rx_line_violation_in_i;
  logic        rx_serial_out_o, rx_bit_valid_o, rx_pos_bit_o, rx_neg_bit_o;
  logic [2:0]  tx_seen;
  logic [2:0]  rx_q[$];
  int          mismatches = 0;
  int          comparisons = 0;

  lspi_line_pins #(.TX_HALF_CYC(HALF)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_pos_bit_i(tx_pos_bit_i), .tx_neg_bit_i(tx_neg_bit_i),
    .tx_uni_bit_i(tx_uni_bit_i), .tx_take_o(tx_take_o), .tx_pos_rail_o(tx_pos_rail_o),
    .tx_neg_rail_o(tx_neg_rail_o), .tx_line_clock_o(tx_line_clock_o),
    .tx_unipolar_data_o(tx_unipolar_data_o), .tx_analog_pos_o(tx_analog_pos_o),
    .tx_analog_neg_o(tx_analog_neg_o), .rx_line_clock_i(rx_line_clock_i),
    .rx_pos_rail_i(rx_pos_rail_i), .rx_neg_rail_i(rx_neg_rail_i),
    .rx_unipolar_data_i(rx_unipolar_data_i), .rx_line_violation_in_i(rx_line_violation_in_i),
    .rx_serial_out_o(rx_serial_out_o), .rx_bit_valid_o(rx_bit_valid_o),
    .rx_pos_bit_o(rx_pos_bit_o), .rx_neg_bit_o(rx_neg_bit_o));

  lspi_far_model far (
    .tx_clk_inv_i(tx_clk_inv), .tx_line_clock_i(tx_line_clock_o),
    .tx_pos_rail_i(tx_pos_rail_o), .tx_neg_rail_i(tx_neg_rail_o),
    .tx_unipolar_data_i(tx_unipolar_data_o), .rx_line_clock_o(rx_line_clock_i),
    .rx_pos_rail_o(rx_pos_rail_i), .rx_neg_rail_o(rx_neg_rail_i),
    .rx_unipolar_data_o(rx_unipolar_data_i),
    .rx_line_violation_in_o(rx_line_violation_in_i), .tx_seen_o(tx_seen));

  // 100 MHz system clock
  always #5 clock_i = ~clock_i;

  // every accepted receive bit, as {serial, pos, neg}
  always @(posedge clock_i)
    if (rx_bit_valid_o === 1'b1)
      rx_q.push_back({rx_serial_out_o, rx_pos_bit_o, rx_neg_bit_o});

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle strobes; the trailing edge keeps back-to-back calls race free
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o & m, e);
  endtask

  // expected {pos, neg, data} pins for framer bits b under control c
  function automatic logic [2:0] tx_exp(input logic [8:0] c, input logic [2:0] b);
    logic bip;
    bip = c[1:0] < 2'b10;
    tx_exp = {(bip && c[3]) ? b[2:1] ^ {2{c[5]}} : 2'b00,
              (c[1:0] == 2'b10 && c[3]) ? b[0] ^ c[5] : 1'b0};
  endfunction

  task automatic tx_case(input logic [8:0] c);
    logic [2:0] cur, prev, seen0;
    logic       clk_on;
    int         w;
    clk_on = c[3] && c[1:0] != 2'b11;
    cur = 3'h0;
    prev = 3'h0;
    tx_clk_inv <= c[4];
    reg_write(8'h00, {23'h0, c});
    for (int k = 0; k < 7; k++)
    begin
      w = 0;
      @(posedge clock_i);
      #1;
      while (tx_take_o !== 1'b1 && w < 50)
      begin
        @(posedge clock_i);
        #1;
        w++;
      end
      check({31'h0, tx_take_o}, {31'h0, clk_on});
      // the pins move one cycle after the load pulse
      @(posedge clock_i);
      #1;
      if (k == 0)
        seen0 = tx_seen;
      if (k > 0)
      begin
        check({tx_pos_rail_o, tx_neg_rail_o, tx_unipolar_data_o}, tx_exp(c, cur));
        check({tx_analog_pos_o, tx_analog_neg_o},
              (c[1:0] < 2'b10 && c[2]) ? cur[2:1] : 2'b00);
        check(tx_line_clock_o, clk_on ? !c[4] : 1'b0);
      end
      if (k > 1)
        check(tx_seen, clk_on ? tx_exp(c, prev) : seen0);
      prev = cur;
      cur = {k[0], k[1] & ~k[0], k[0] ^ k[1]};
      @(posedge clock_i);
      {tx_pos_bit_i, tx_neg_bit_i, tx_uni_bit_i} <= cur;
    end
  endtask

  // mode off with pins and line unit enabled: every transmit pin stays low
  task automatic tx_off();
    logic any;
    any = 1'b0;
    reg_write(8'h00, 32'h0000_000F);
    repeat (40)
    begin
      @(posedge clock_i);
      #1;
      any = any | tx_pos_rail_o | tx_neg_rail_o | tx_line_clock_o | tx_unipolar_data_o
            | tx_analog_pos_o | tx_analog_neg_o;
    end
    check(any, 1'b0);
  endtask

  task automatic rx_case(input logic [8:0] c, input logic [7:0] p, input logic [7:0] ng,
                         input logic [7:0] d, input logic [7:0] v);
    logic bip, unipolar_mode, di, pp, nn;
    int   cnt;
    bip = c[1:0] < 2'b10 && !c[2];
    unipolar_mode = c[1:0] == 2'b10;
    di = c[7];
    cnt = 0;
    reg_write(8'h00, {23'h0, c});
    repeat (4) @(posedge clock_i);
    reg_write(8'h08, 32'h0000_0000);
    rx_q.delete();
    far.send(p, ng, d, v);
    repeat (10) @(posedge clock_i);
    check(rx_q.size(), (bip || unipolar_mode) ? 8 : 0);
    for (int i = 0; i < 8; i++)
      cnt += (unipolar_mode && (v[i] ^ di)) ? 1 : 0;
    foreach (rx_q[i])
    begin
      pp = bip ? p[i] ^ di : 1'b0;
      nn = bip ? ng[i] ^ di : 1'b0;
      check(rx_q[i], {c[8] & (bip ? pp | nn : unipolar_mode & (d[i] ^ di)), pp, nn});
    end
    reg_read(8'h08, 32'h0000_FFFF, cnt);
  endtask

  // cut a hang short well past the expected run length
  initial
  begin
    #100_000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    reg_read(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    reg_read(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    reg_read(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    reg_write(8'h00, 32'hFFFF_FFFF);
    reg_write(8'h0C, 32'h0000_0000);
    reg_read(8'h00, 32'hFFFF_FFFF, 32'h0000_01FF);
    tx_off();
    tx_case(9'h009);
    tx_case(9'h03C);
    tx_case(9'h03A);
    tx_case(9'h005);
    rx_case(9'h101, 8'hA6, 8'h50, 8'hA5, 8'hFF);
    reg_read(8'h04, 32'h0000_001F, 32'h0000_001B);
    reg_write(8'h04, 32'h0000_0001);
    reg_read(8'h04, 32'h0000_001F, 32'h0000_001A);
    rx_case(9'h1C0, 8'h3C, 8'h81, 8'h00, 8'h00);
    rx_case(9'h1C2, 8'h00, 8'h00, 8'h96, 8'h0F);
    rx_case(9'h002, 8'hFF, 8'hFF, 8'hFF, 8'h31);
    rx_case(9'h105, 8'hFF, 8'hFF, 8'h5A, 8'hFF);
    rx_case(9'h103, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
    print_verdict();
  end
endmodule // lspi_line_pins_test
